/* File: oss_top.sv */
// How it works
// - add signed 16-bit offset per channel first
// - multiply by signed gain, negative inverts
// - clamp each channel between programmed limits
// - internal error substitutes error duty on pwm, unless mag_low or supply error is also set
// - error duty 12 bits at 2 kHz, else 13
// - error duty resets to 0FEB, a 99.5 percent code only at 2 kHz (12 bits); reset selects 13 bits
// - switch thresholds from two threshold registers
// - setup bit 15 enables switch function
// - bit 14 sets switch state after reset
// - bit 13 selects active low level
// - bit 12 inverts the switch output
// - four-bit field selects switch source signal
// - hysteresis step is eight source counts
// - supply register holds over/under thresholds
`timescale 1ns/1ps
`default_nettype none
module oss_top
    import oss_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire oss_axi_req_t axi_req,
    output oss_axi_rsp_t      axi_rsp,
    input  wire oss_sample_t  sample_in,
    input  wire oss_src_bus_t switch_sources,
    input  wire oss_err_t     err_in,
    output oss_out_t          out,
    output logic [7:0]        overvoltage_threshold,
    output logic [7:0]        undervoltage_threshold,
    output logic              irq
);
    // ==========================================================
    // functions
    function automatic logic addr_hit(input logic [7:0] a);
        if (a[1:0] != 2'h0) begin
            return 1'b0;
        end else if (int'(a[7:2]) <= IDX_IRQ_MASK) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : addr_hit

    function automatic oss_chan_t scale(input logic [15:0] x, input logic [15:0] ofs,
                                        input logic [15:0] gain, input logic [15:0] lo,
                                        input logic [15:0] hi);
        logic signed [16:0] sum;
        logic signed [33:0] prod;
        logic signed [19:0] q;
        logic signed [15:0] r;
        oss_chan_t          c;
        sum = $signed({x[15], x}) + $signed({ofs[15], ofs});
        prod = 34'(sum) * $signed(34'($signed(gain)));
        q = 20'(prod >>> GAIN_FRAC);
        if (q > 20'sh07FFF) begin
            r = 16'sh7FFF;
        end else if (q < -20'sh08000) begin
            r = -16'sh8000;
        end else begin
            r = q[15:0];
        end
        c.clamped = 1'b0;
        if (r < $signed(lo)) begin
            r = $signed(lo);
            c.clamped = 1'b1;
        end
        if (r > $signed(hi)) begin
            r = $signed(hi);
            c.clamped = 1'b1;
        end
        c.val = r;
        return c;
    endfunction : scale

    function automatic logic [15:0] pick_source(input oss_src_bus_t b,
                                                input logic [3:0] code);
        case (oss_src_t'(code))
            SRC_OUT_P:   return b.out_p;
            SRC_SP_P:    return b.sp_out_p;
            SRC_ANGLE_P: return b.angle_p;
            SRC_MAG_P:   return b.primary_vector_magnitude;
            SRC_OUT_S:   return b.out_s;
            SRC_SP_S:    return b.sp_out_s;
            SRC_MAG_S:   return b.secondary_vector_magnitude;
            SRC_FIELD:   return b.field_magnitude;
            SRC_UCOMP_A: return b.user_compensated_ch_a;
            SRC_UCOMP_B, SRC_UCOMP_B2: return b.user_compensated_ch_b;
            SRC_COMP_A:  return b.compensated_ch_a;
            SRC_COMP_C:  return b.compensated_ch_c;
            SRC_TEMP:    return b.die_temperature;
            default:     return 16'h0000;
        endcase
    endfunction : pick_source

    // ==========================================================
    // state
    oss_state_t state_reg;
    oss_state_t state_next;
    logic [15:0] setup;
    logic        sw_en;
    logic        is_2k;
    logic        err_sub;
    logic [12:0] err_duty;
    logic [15:0] sw_src;
    logic [15:0] hyst_cnt;
    logic [15:0] off_lim;
    oss_chan_t   res_p;
    oss_chan_t   res_s;

    assign setup    = state_reg.regs[IDX_SETUP];
    assign sw_en    = setup[SW_EN_BIT];
    assign is_2k    = state_reg.regs[IDX_CTRL][CTRL_2K_BIT];
    assign err_sub  = err_in.internal && !err_in.mag_low && !err_in.supply;
    assign err_duty = is_2k ? 13'(state_reg.regs[IDX_DUTY][DUTY_W12-1:0])
                            : state_reg.regs[IDX_DUTY][DUTY_W13-1:0];
    assign sw_src   = pick_source(switch_sources, setup[SW_SRC_LSB +: 4]);
    assign hyst_cnt = {5'h00, setup[SW_HYST_LSB +: 8], 3'h0};
    assign off_lim  = (state_reg.regs[IDX_THR_B] > hyst_cnt)
                    ? state_reg.regs[IDX_THR_B] - hyst_cnt : 16'h0000;
    assign res_p = scale(sample_in.ch_p, state_reg.regs[IDX_OFS_P],
                         state_reg.regs[IDX_GAIN_P], state_reg.regs[IDX_LO_P],
                         state_reg.regs[IDX_HI_P]);
    assign res_s = scale(sample_in.ch_s, state_reg.regs[IDX_OFS_S],
                         state_reg.regs[IDX_GAIN_S], state_reg.regs[IDX_LO_S],
                         state_reg.regs[IDX_HI_S]);

    // ==========================================================
    // next state
    always_comb begin
        logic [15:0]     wv;
        logic [NIRQ-1:0] ev;
        logic [NIRQ-1:0] clr;
        int              idx;
        int              ridx;
        state_next = state_reg;
        wv   = 16'h0000;
        ev   = '0;
        clr  = '0;
        idx  = int'(state_reg.awaddr[7:2]);
        ridx = int'(axi_req.araddr[7:2]);
        // write address and data, either order
        if (axi_req.awvalid && axi_rsp.awready) begin
            state_next.aw_got = 1'b1;
            state_next.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            state_next.w_got = 1'b1;
            state_next.wdata = axi_req.wdata[15:0];
            state_next.wstrb = axi_req.wstrb[1:0];
        end
        if (state_reg.bvalid && axi_req.bready) begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.aw_got && state_reg.w_got) begin
            state_next.aw_got = 1'b0;
            state_next.w_got  = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp  = RESP_OKAY;
            if (!addr_hit(state_reg.awaddr)) begin
                state_next.bresp = RESP_SLVERR;
            end else if (idx < NREG) begin
                wv = state_reg.regs[idx];
                if (state_reg.wstrb[0]) begin
                    wv[7:0] = state_reg.wdata[7:0];
                end
                if (state_reg.wstrb[1]) begin
                    wv[15:8] = state_reg.wdata[15:8];
                end
                if ((idx >= IDX_LO_P) && (idx <= IDX_HI_S) && wv[15]) begin
                    wv = 16'h0000;
                end
                state_next.regs[idx] = wv;
                if (idx == IDX_DUTY) begin
                    state_next.duty_written = 1'b1;
                end
            end else if (idx == IDX_IRQ_ST) begin
                clr = state_reg.wstrb[0] ? state_reg.wdata[NIRQ-1:0] : '0;
            end else if (idx == IDX_IRQ_MASK) begin
                if (state_reg.wstrb[0]) begin
                    state_next.irq_mask = state_reg.wdata[NIRQ-1:0];
                end
            end
        end
        // read channel
        if (state_reg.rvalid && axi_req.rready) begin
            state_next.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = RESP_OKAY;
            state_next.rdata  = 16'h0000;
            if (!addr_hit(axi_req.araddr)) begin
                state_next.rresp = RESP_SLVERR;
            end else if (ridx < NREG) begin
                state_next.rdata = state_reg.regs[ridx];
            end else if (ridx == IDX_STATUS) begin
                state_next.rdata = {13'h0000, state_reg.out.switch_pin,
                                    state_reg.out.pwm_err, state_reg.sw_on};
            end else if (ridx == IDX_IRQ_ST) begin
                state_next.rdata = 16'(state_reg.irq_st);
            end else begin
                state_next.rdata = 16'(state_reg.irq_mask);
            end
        end
        // output scaling datapath
        state_next.out.valid = sample_in.valid;
        if (sample_in.valid) begin
            state_next.out.ch_p = res_p.val;
            state_next.out.ch_s = res_s.val;
            ev[IRQ_CLAMP] = res_p.clamped || res_s.clamped;
        end
        // pwm duty with error substitution
        state_next.out.pwm_err = err_sub;
        if (err_sub) begin
            state_next.out.pwm_duty = err_duty;
        end else if (is_2k) begin
            state_next.out.pwm_duty = 13'(state_reg.out.ch_p[14:3]);
        end else begin
            state_next.out.pwm_duty = state_reg.out.ch_p[14:2];
        end
        ev[IRQ_ERR] = err_sub && !state_reg.out.pwm_err;
        // switch hysteresis state
        if (!state_reg.sw_init) begin
            state_next.sw_init = 1'b1;
            state_next.sw_on   = setup[SW_START_BIT];
        end else if (!sw_en) begin
            state_next.sw_on = setup[SW_START_BIT];
        end else if (sw_src >= state_reg.regs[IDX_THR_A]) begin
            state_next.sw_on = 1'b1;
        end else if (sw_src < off_lim) begin
            state_next.sw_on = 1'b0;
        end
        ev[IRQ_SW_ON]  = sw_en && state_reg.sw_init && state_next.sw_on
                      && !state_reg.sw_on;
        ev[IRQ_SW_OFF] = sw_en && state_reg.sw_init && !state_next.sw_on
                      && state_reg.sw_on;
        // pin: disabled level equals bit 13, off level is bit 13 xor bit 12
        state_next.out.switch_pin = sw_en
            ? (state_next.sw_on ^ setup[SW_POL_BIT] ^ setup[SW_LVL_BIT])
            : setup[SW_LVL_BIT];
        // sticky events, set wins over clear
        state_next.irq_st = (state_reg.irq_st & ~clr) | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= '0;
            state_reg.regs <= RST_REGS;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign axi_rsp.awready = !state_reg.aw_got && !state_reg.bvalid;
    assign axi_rsp.wready  = !state_reg.w_got && !state_reg.bvalid;
    assign axi_rsp.bvalid  = state_reg.bvalid;
    assign axi_rsp.bresp   = state_reg.bresp;
    assign axi_rsp.arready = !state_reg.rvalid;
    assign axi_rsp.rvalid  = state_reg.rvalid;
    assign axi_rsp.rdata   = {16'h0000, state_reg.rdata};
    assign axi_rsp.rresp   = state_reg.rresp;
    assign out = state_reg.out;
    assign overvoltage_threshold  = state_reg.regs[IDX_SUPPLY][SUP_OV_LSB +: 8];
    assign undervoltage_threshold = state_reg.regs[IDX_SUPPLY][SUP_UV_LSB +: 8];
    assign irq = |(state_reg.irq_st & state_reg.irq_mask);

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_err_req;
        err_in.internal && !err_in.mag_low && !err_in.supply;
    endsequence
    sequence s_err_out;
        out.pwm_err && out.pwm_duty == $past(err_duty);
    endsequence
    sequence s_sw_high;
        sw_en && state_reg.sw_init && sw_src >= state_reg.regs[IDX_THR_A];
    endsequence

    a_error_subst: assert property (s_err_req |=> s_err_out)
        else $error("error duty not substituted");
    a_no_subst_mag: assert property (err_in.mag_low |=> !out.pwm_err)
        else $error("substitution on low field");
    a_duty_width: assert property (out.pwm_err && $past(is_2k) |-> !out.pwm_duty[12])
        else $error("duty wider than 12 bits at 2 kHz");
    a_duty_default: assert property (!state_reg.duty_written |->
        state_reg.regs[IDX_DUTY] == RST_DUTY)
        else $error("error duty default lost");
    a_out_limits: assert property (out.valid && $stable(state_reg.regs[IDX_HI_P]) |->
        $signed(out.ch_p) <= $signed(state_reg.regs[IDX_HI_P]))
        else $error("primary output above upper limit");
    a_scale_order: assert property (sample_in.valid |=> out.valid &&
        out.ch_p == $past(res_p.val) && out.ch_s == $past(res_s.val))
        else $error("scaled sample not delivered");
    a_switch_off: assert property (!sw_en |=> out.switch_pin == $past(setup[SW_LVL_BIT]))
        else $error("disabled switch not at inactive level");
    a_startup_state: assert property ($rose(state_reg.sw_init) |->
        state_reg.sw_on == $past(setup[SW_START_BIT]))
        else $error("switch start-up state wrong");
    a_switch_on: assert property (s_sw_high |=> state_reg.sw_on &&
        out.switch_pin == !($past(setup[SW_POL_BIT]) ^ $past(setup[SW_LVL_BIT])))
        else $error("switch not on above on threshold");
    a_hyst_hold: assert property (sw_en && state_reg.sw_init && state_reg.sw_on &&
        sw_src >= off_lim |=> state_reg.sw_on)
        else $error("switch left on state inside hysteresis");
    a_write_resp: assert property (state_reg.aw_got && state_reg.w_got |=> ##[0:1] axi_rsp.bvalid)
        else $error("write response missing");
endmodule : oss_top
`default_nettype wire

/* File: oss_pkg.sv */
`default_nettype none
package oss_pkg;
    // ==========================================================
    // register indices, byte address = index * 4
    localparam int NREG         = 14;
    localparam int IDX_OFS_P    = 0;
    localparam int IDX_OFS_S    = 1;
    localparam int IDX_GAIN_P   = 2;
    localparam int IDX_GAIN_S   = 3;
    localparam int IDX_LO_P     = 4;
    localparam int IDX_HI_P     = 5;
    localparam int IDX_LO_S     = 6;
    localparam int IDX_HI_S     = 7;
    localparam int IDX_DUTY     = 8;
    localparam int IDX_SETUP    = 9;
    localparam int IDX_THR_A    = 10;
    localparam int IDX_THR_B    = 11;
    localparam int IDX_SUPPLY   = 12;
    localparam int IDX_CTRL     = 13;
    localparam int IDX_STATUS   = 14;
    localparam int IDX_IRQ_ST   = 15;
    localparam int IDX_IRQ_MASK = 16;
    // ==========================================================
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h4000;
    localparam logic [15:0] RST_HI   = 16'h7FFF;
    localparam logic [15:0] RST_DUTY = 16'h0FEB;
    localparam logic [NREG-1:0][15:0] RST_REGS = {
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_DUTY,
        RST_HI, RST_ZERO, RST_HI, RST_ZERO, RST_GAIN, RST_GAIN,
        RST_ZERO, RST_ZERO};
    // ==========================================================
    // field positions and scaling
    localparam int SW_EN_BIT    = 15;
    localparam int SW_START_BIT = 14;
    localparam int SW_LVL_BIT   = 13;
    localparam int SW_POL_BIT   = 12;
    localparam int SW_SRC_LSB   = 8;
    localparam int SW_HYST_LSB  = 0;
    localparam int HYST_SHIFT   = 3;
    localparam int SUP_OV_LSB   = 8;
    localparam int SUP_UV_LSB   = 0;
    localparam int CTRL_2K_BIT  = 0;
    localparam int DUTY_W12     = 12;
    localparam int DUTY_W13     = 13;
    localparam int GAIN_FRAC    = 14;
    localparam int NIRQ         = 4;
    localparam int IRQ_SW_ON    = 0;
    localparam int IRQ_SW_OFF   = 1;
    localparam int IRQ_ERR      = 2;
    localparam int IRQ_CLAMP    = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // types
    typedef enum logic [3:0] {
        SRC_OUT_P, SRC_SP_P, SRC_ANGLE_P, SRC_MAG_P,
        SRC_OUT_S, SRC_SP_S, SRC_NONE_6, SRC_MAG_S,
        SRC_FIELD, SRC_UCOMP_A, SRC_UCOMP_B, SRC_UCOMP_B2,
        SRC_COMP_A, SRC_COMP_C, SRC_NONE_14, SRC_TEMP
    } oss_src_t;
    typedef struct packed {
        logic [15:0] out_p, sp_out_p, angle_p, primary_vector_magnitude;
        logic [15:0] out_s, sp_out_s, secondary_vector_magnitude;
        logic [15:0] field_magnitude, user_compensated_ch_a;
        logic [15:0] user_compensated_ch_b, compensated_ch_a;
        logic [15:0] compensated_ch_c, die_temperature;
    } oss_src_bus_t;
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [7:0] araddr;
        logic rready;
    } oss_axi_req_t;
    typedef struct packed {
        logic awready, wready, bvalid; logic [1:0] bresp;
        logic arready, rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } oss_axi_rsp_t;
    typedef struct packed {
        logic valid; logic [15:0] ch_p, ch_s;
    } oss_sample_t;
    typedef struct packed {
        logic internal, mag_low, supply;
    } oss_err_t;
    typedef struct packed {
        logic valid; logic [15:0] ch_p, ch_s;
        logic [12:0] pwm_duty; logic pwm_err, switch_pin;
    } oss_out_t;
    typedef struct packed {
        logic [15:0] val; logic clamped;
    } oss_chan_t;
    typedef struct packed {
        logic [NREG-1:0][15:0] regs;
        logic [NIRQ-1:0] irq_st, irq_mask;
        logic aw_got, w_got, bvalid, rvalid;
        logic [7:0] awaddr;
        logic [15:0] wdata, rdata;
        logic [1:0] wstrb, bresp, rresp;
        logic sw_on, sw_init, duty_written;
        oss_out_t out;
    } oss_state_t;
endpackage : oss_pkg
`default_nettype wire

/* File: oss_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external controller: watches pwm duty and switch pin
module oss_ctrl_model
    import oss_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire oss_out_t    out,
    output logic [12:0]      duty_seen,
    output int               sw_edges
);
    logic last_pin;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_seen <= 13'h0000;
            sw_edges  <= 0;
            last_pin  <= 1'b0;
        end else begin
            if (out.pwm_err) begin
                duty_seen <= out.pwm_duty;
            end
            if (out.switch_pin != last_pin) begin
                sw_edges <= sw_edges + 1;
            end
            last_pin <= out.switch_pin;
        end
    end
endmodule : oss_ctrl_model
`default_nettype wire

/* File: oss_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_tb_top
    import oss_pkg::*;
;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    oss_axi_req_t axi_req = '0;
    oss_axi_rsp_t axi_rsp;
    oss_sample_t  sample_in = '0;
    oss_src_bus_t switch_sources = '0;
    oss_err_t     err_in = '0;
    oss_out_t     out;
    logic [7:0]   ov_thr, uv_thr;
    logic         irq;
    logic [12:0]  duty_seen;
    int           sw_edges;
    int           n_errors = 0, num_checks = 0, cycles = 0;
    logic [31:0]  seed = 32'h91477EEA;
    logic [31:0]  rd;
    logic [1:0]   rr;
    logic [1:0]   br;
    int           e0;
    logic [15:0]  r [8];
    logic [15:0]  x, y, t;
    logic         b12, b13;
    always #25 aclk = ~aclk;
    oss_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .sample_in(sample_in), .switch_sources(switch_sources), .err_in(err_in), .out(out),
        .overvoltage_threshold(ov_thr), .undervoltage_threshold(uv_thr), .irq(irq));
    oss_ctrl_model i_ctrl (.aclk(aclk), .aresetn(aresetn), .out(out),
        .duty_seen(duty_seen), .sw_edges(sw_edges));
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_ch(logic [15:0] v, o, g, lo, hi);
        logic signed [16:0] s;
        logic signed [33:0] p;
        logic [15:0]        q;
        s = $signed({v[15], v}) + $signed({o[15], o});
        p = (s * $signed(g)) >>> 14;
        if (p > 34'sd32767) q = 16'h7FFF;
        else if (p < -34'sd32768) q = 16'h8000;
        else q = p[15:0];
        if ($signed(q) < $signed(lo)) q = lo;
        if ($signed(q) > $signed(hi)) q = hi;
        return q;
    endfunction : exp_ch
    function automatic int fld(int c);
        case (c)
            6, 14:   return -1;
            7, 8, 9: return c - 1;
            10, 11:  return 9;
            12, 13:  return c - 2;
            15:      return 12;
            default: return c;
        endcase
    endfunction : fld
    task automatic check_eq(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask : check_eq
    task automatic final_report();
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic wr(int idx, logic [15:0] d);
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= 8'(idx * 4);
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= {16'h0000, d};
        axi_req.wstrb   <= 4'hF;
        axi_req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        br = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr
    task automatic rdr(logic [7:0] a);
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        axi_req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid);
        rd = axi_rsp.rdata;
        rr = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rdr
    task automatic set_src(int c, logic [15:0] v);
        logic [12:0][15:0] a;
        for (int i = 0; i < 13; i++) a[i] = (v >= 16'h1000) ? 16'h0000 : 16'hFFFF;
        if (fld(c) >= 0) a[12 - fld(c)] = v;
        @(posedge aclk);
        switch_sources <= oss_src_bus_t'(a);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask : set_src
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            final_report();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i <= IDX_SETUP; i++) begin
            rdr(8'(i * 4));
            t = (i == 2 || i == 3) ? RST_GAIN : (i == 5 || i == 7) ? RST_HI : 16'h0000;
            if (i == IDX_DUTY) t = RST_DUTY;
            check_eq("reset value", rd, {16'h0000, t});
        end
        rdr(8'h44);
        check_eq("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
        wr(17, 16'hFFFF);
        check_eq("unmapped write resp", 32'(br), 32'(RESP_SLVERR));
        // datapath with random offset, gain and limits
        for (int k = 0; k < 30; k++) begin
            for (int i = 0; i < 8; i++) r[i] = 16'(rnd());
            r[4] = r[4] & 16'h7FFF;
            r[5] = r[5] & 16'h7FFF;
            if (r[4] > r[5]) begin
                t = r[4];
                r[4] = r[5];
                r[5] = t;
            end
            if (k == 0) r[2] = 16'hC000;
            r[6] = r[4];
            r[7] = r[5];
            for (int i = 0; i < 8; i++) wr(i, r[i]);
            for (int j = 0; j < 3; j++) begin
                x = 16'(rnd());
                y = (j == 0) ? 16'h7FFF : 16'(rnd());
                @(posedge aclk);
                sample_in <= '{valid: 1'b1, ch_p: x, ch_s: y};
                @(posedge aclk);
                sample_in.valid <= 1'b0;
                for (int w = 0; w < 4 && out.valid !== 1'b1; w++) @(negedge aclk);
                check_eq("out valid", 32'(out.valid), 32'h1);
                check_eq("ch_p", 32'(out.ch_p), 32'(exp_ch(x, r[0], r[2], r[4], r[5])));
                check_eq("ch_s", 32'(out.ch_s), 32'(exp_ch(y, r[1], r[3], r[6], r[7])));
            end
        end
        // error duty substitution and interrupt
        wr(IDX_IRQ_MASK, 16'h0004);
        wr(IDX_DUTY, 16'h1ABC);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CTRL, 16'(m & 1));
            @(posedge aclk);
            err_in <= '{internal: 1'b1, mag_low: m == 2, supply: m == 3};
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            check_eq("pwm_err", 32'(out.pwm_err), 32'(m < 2));
            if (m < 2) check_eq("duty", 32'(duty_seen), m ? 32'h0ABC : 32'h1ABC);
            if (m == 0) check_eq("irq set", 32'(irq), 32'h1);
            @(posedge aclk);
            err_in <= '0;
            wr(IDX_IRQ_ST, 16'h0004);
            @(negedge aclk);
            check_eq("irq clear", 32'(irq), 32'h0);
        end
        // supply thresholds
        t = 16'(rnd());
        wr(IDX_SUPPLY, t);
        check_eq("write okay", 32'(br), 32'(RESP_OKAY));
        rdr(8'(IDX_SUPPLY * 4));
        check_eq("supply read", rd, {16'h0000, t});
        check_eq("ov", 32'(ov_thr), 32'(t[15:8]));
        check_eq("uv", 32'(uv_thr), 32'(t[7:0]));
        // switch sources, level, polarity, hysteresis
        wr(IDX_THR_A, 16'h1000);
        wr(IDX_THR_B, 16'h0800);
        for (int c = 0; c < 17; c++) begin
            t = 16'(rnd());
            b12 = t[0];
            b13 = t[1];
            wr(IDX_SETUP, {1'b0, c == 16, b13, b12, 4'(c), 8'h04});
            set_src(c % 16, 16'h0900);
            check_eq("pin off", 32'(out.switch_pin), 32'(b13));
            wr(IDX_SETUP, {1'b1, c == 16, b13, b12, 4'(c), 8'h04});
            if (c == 16) begin
                set_src(0, 16'h0900);
                check_eq("pin start", 32'(out.switch_pin), 32'(!(b12 ^ b13)));
            end else begin
                set_src(c, 16'h2000);
                t = {15'h0000, fld(c) >= 0};
                check_eq("pin on", 32'(out.switch_pin), 32'(t[0] ^ b12 ^ b13));
                set_src(c, 16'h07E8);
                check_eq("pin hold", 32'(out.switch_pin), 32'(t[0] ^ b12 ^ b13));
                e0 = sw_edges;
                set_src(c, 16'h07DF);
                check_eq("pin low", 32'(out.switch_pin), 32'(b12 ^ b13));
                check_eq("pin edges", 32'(sw_edges - e0), 32'(t[0]));
            end
        end
        rdr(8'(IDX_STATUS * 4));
        check_eq("status", rd, 32'({!(b12 ^ b13), 2'b01}));
        final_report();
    end
endmodule : oss_tb_top
`default_nettype wire
